// ==== rtl/lane_sync_rx.sv ====
`timescale 1ns/1ns
// Function
// - lane fifos absorb two cycles of drift
// - fifo full and empty in two registers
// - lane fifo error gated by enable bit 2
// - status bit 2 reports, write clears interrupt
// - each logical lane picks physical source lane
// - reset gives identity lane mapping
// - inversion bit x inverts logical lane x
// - two deframers paged by bit 2
// - four decoded octets per cycle per lane
// - unpack using software written link parameters
// - self synchronous descrambler 1+x^14+x^15
// - descramble only while enable bit set
// - oneshot request aligns on next edge
// - first deframer subclass 1 sysref, subclass 0 internal edge
// - rotation done held until new request
// - sysref rising edge, sampled at dac/4
// - continuous, strobed or gapped sysref accepted
// - skip count edges ignored before alignment
// - later edges checked against lmfc window
// - window in dac clocks, low bits ignored
// - new sync drops then restores sync requests
// - subclass field bits 7:5 at 0x458
module lane_sync_rx
   import lane_sync_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // lane data, decoded octets, four per cycle
   input wire lane_bus_t serial_lane_input_i,
   input wire logic [NUM_LANES-1:0] lane_valid_i,
   // sysref pin
   input wire logic sysref_i,
   // deframed output per logical lane
   output lane_bus_t frame_data_o,
   output logic [NUM_LANES-1:0] frame_valid_o,
   // link status
   output logic [1:0] link_sync_request_out_o,
   output logic irq_o,
   output logic sysref_coupling_select_o
);

   typedef struct packed {
      logic [7:0] irq_en;
      logic [7:0] irq_st;
      logic [7:0] skip;
      logic [7:0] win;
      logic req;
      logic done;
      logic [7:0] sref_cfg;
      logic [7:0] page;
      logic [NUM_LANES-1:0][2:0] src;
      logic [7:0] inv;
      logic [1:0][7:0] scr_cfg;
      logic [1:0][7:0] sub_cfg;
      logic [NUM_LANES-1:0][FIFO_DEPTH-1:0][WORD_W-1:0] mem;
      logic [NUM_LANES-1:0][PTR_W-1:0] wp;
      logic [NUM_LANES-1:0][PTR_W-1:0] rp;
      logic [NUM_LANES-1:0][14:0] lfsr;
      sync_state_t st;
      logic [7:0] skip_cnt;
      logic [3:0] lmfc;
      logic [1:0] div;
      logic sref_ff1;
      logic sref_ff2;
      logic sref_prev;
      logic [7:0] rdata;
      logic irq;
      logic [1:0] sync_out;
      lane_bus_t fdata;
      logic [NUM_LANES-1:0] fvalid;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // descramble one word msb first; returns {new state, data}
   function automatic logic [46:0] descramble(input logic [31:0] w,
                                              input logic [14:0] s);
      logic [31:0] o;
      logic [14:0] t;
      o = '0;
      t = s;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         o[i] = w[i] ^ t[13] ^ t[14];
         t = {t[13:0], w[i]};
      end
      return {t, o};
   endfunction

   // reset image: identity map, lane count of four per link
   function automatic state_t reset_state();
      state_t s;
      s = '0;
      for (int l = 0; l < NUM_LANES; l++) begin
         s.src[l] = 3'(l);
      end
      s.scr_cfg[0] = LANE_COUNT_RESET;
      s.scr_cfg[1] = LANE_COUNT_RESET;
      s.sync_out = 2'h3;
      s.st = SYNC_IDLE;
      return s;
   endfunction

   logic [NUM_LANES-1:0] fifo_full;
   logic [NUM_LANES-1:0] fifo_empty;
   logic fifo_err;
   logic pop;
   logic tick;
   logic sref_edge;
   logic align_edge;
   logic subclass1;
   logic pg;
   logic [3:0] dev;
   logic [WORD_W-1:0] xbar;
   logic [46:0] dsc;
   logic [2:0] lane_cnt;
   logic jitter_hit;

   // per physical lane fifo flags
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_flags
         assign fifo_empty[g] = state_reg.wp[g] == state_reg.rp[g];
         assign fifo_full[g] = (state_reg.wp[g][1:0] == state_reg.rp[g][1:0])
                               && (state_reg.wp[g][2] != state_reg.rp[g][2]);
      end
   endgenerate

   // sample tick and sysref rising edge at the divided rate
   assign tick = state_reg.div == SAMPLE_DIV_LAST;
   // one edge per pulse whatever the gaps between pulses
   assign sref_edge = tick && state_reg.sref_ff2
                      && !state_reg.sref_prev;
   assign subclass1 = state_reg.sub_cfg[0][SUBCLASS_LSB +: 3]
                      == SUBCLASS_ONE;
   assign pg = state_reg.page[PAGE_SEL_BIT];
   // subclass 0 aligns on the next processing clock edge
   assign align_edge = subclass1 ? sref_edge : 1'b1;
   // lanes are released together only once every lane holds a word
   assign pop = ~|fifo_empty;
   // aggregate error: a write that finds its fifo full is lost
   assign fifo_err = |(lane_valid_i & fifo_full);
   // distance of a sysref edge from the nearest lmfc boundary
   assign dev = (state_reg.lmfc < LMFC_HALF) ? state_reg.lmfc
                : 4'(LMFC_TICKS - 32'(state_reg.lmfc));

   always_comb begin
      state_next = state_reg;
      xbar = '0;
      dsc = '0;
      lane_cnt = '0;
      jitter_hit = 1'b0;

      // sysref synchroniser, then sample at dac/4
      state_next.sref_ff1 = sysref_i;
      state_next.sref_ff2 = state_reg.sref_ff1;
      state_next.div = state_reg.div + 2'h1;
      if (tick) begin
         state_next.sref_prev = state_reg.sref_ff2;
         state_next.lmfc = (state_reg.lmfc == LMFC_LAST) ? 4'h0
                           : state_reg.lmfc + 4'h1;
      end

      // lane fifos, four deep so two cycles of drift fit either way
      for (int p = 0; p < NUM_LANES; p++) begin
         if (lane_valid_i[p] && !fifo_full[p]) begin
            state_next.mem[p][state_reg.wp[p][1:0]] =
               serial_lane_input_i[p];
            state_next.wp[p] = state_reg.wp[p] + 3'h1;
         end
         if (pop) begin
            state_next.rp[p] = state_reg.rp[p] + 3'h1;
         end
      end

      // crossbar, inversion, descrambler per logical lane
      for (int l = 0; l < NUM_LANES; l++) begin
         xbar = state_reg.mem[state_reg.src[l]]
                [state_reg.rp[state_reg.src[l]][1:0]];
         if (state_reg.inv[l]) begin
            xbar = ~xbar;
         end
         // lanes 0-3 belong to the first deframer, 4-7 to the second
         lane_cnt = state_reg.scr_cfg[l / LANES_PER_LINK][2:0];
         state_next.fvalid[l] = pop
                                && (3'(l % LANES_PER_LINK) <= lane_cnt);
         if (pop) begin
            dsc = descramble(xbar, state_reg.lfsr[l]);
            state_next.lfsr[l] = dsc[46:32];
            if (state_reg.scr_cfg[l / LANES_PER_LINK]
                [DESCRAMBLE_ENABLE_BIT]) begin
               state_next.fdata[l] = dsc[31:0];
            end else begin
               state_next.fdata[l] = xbar;
            end
         end
      end

      // lmfc sync engine
      case (state_reg.st)
         SYNC_IDLE: begin
         end
         SYNC_ARMED: begin
            if (align_edge) begin
               if (state_reg.skip_cnt != 8'h00) begin
                  state_next.skip_cnt = state_reg.skip_cnt - 8'h01;
               end else begin
                  // an aligning tick is itself count zero, so the
                  // counter already moves on to one
                  state_next.lmfc = {3'h0, tick};
                  state_next.done = 1'b1;
                  state_next.sync_out = 2'h3;
                  state_next.st = SYNC_MONITOR;
               end
            end
         end
         SYNC_MONITOR: begin
            // low two window bits are below the sample resolution
            if (subclass1 && sref_edge
                && dev > {2'h0, state_reg.win[5:2]}) begin
               jitter_hit = 1'b1;
            end
         end
         default: state_next.st = SYNC_IDLE;
      endcase

      // register writes
      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            IRQ_ENABLE_LINK_ADDR: state_next.irq_en = reg_req_i.wdata;
            IRQ_STATUS_LINK_ADDR: begin
               // write one to clear; sticky until then
               state_next.irq_st = state_next.irq_st
                                   & ~reg_req_i.wdata;
            end
            SYSREF_EDGE_SKIP_COUNT_ADDR: state_next.skip = reg_req_i.wdata;
            SYSREF_JITTER_WINDOW_ADDR: state_next.win = reg_req_i.wdata;
            ONESHOT_SYNC_CONTROL_ADDR: begin
               state_next.req = reg_req_i.wdata[ONESHOT_REQ_BIT];
               // only a fresh request restarts the rotation
               if (reg_req_i.wdata[ONESHOT_REQ_BIT] && !state_reg.req) begin
                  state_next.done = 1'b0;
                  state_next.skip_cnt = state_reg.skip;
                  state_next.sync_out = 2'h0;
                  state_next.st = SYNC_ARMED;
               end
            end
            SYSREF_RECEIVER_CONFIG_ADDR: state_next.sref_cfg = reg_req_i.wdata;
            LINK_PAGE_SELECT_ADDR: state_next.page = reg_req_i.wdata;
            LANE_MAP_0_1_ADDR, LANE_MAP_2_3_ADDR,
            LANE_MAP_4_5_ADDR, LANE_MAP_6_7_ADDR: begin
               state_next.src[{reg_req_i.addr[1:0], 1'b0}] =
                  reg_req_i.wdata[2:0];
               state_next.src[{reg_req_i.addr[1:0], 1'b1}] =
                  reg_req_i.wdata[SRC_HI_LSB +: 3];
            end
            LANE_POLARITY_INVERT_ADDR: state_next.inv = reg_req_i.wdata;
            DESCRAMBLER_CONFIG_ADDR: begin
               state_next.scr_cfg[pg] = reg_req_i.wdata;
            end
            LINK_SUBCLASS_CONFIG_ADDR: begin
               state_next.sub_cfg[pg] = reg_req_i.wdata;
            end
            default: ;
         endcase
      end

      // hardware set wins over a clear in the same cycle
      if (fifo_err) begin
         state_next.irq_st[IRQ_LANE_FIFO_BIT] = 1'b1;
      end
      if (jitter_hit) begin
         state_next.irq_st[IRQ_JITTER_BIT] = 1'b1;
      end

      // register reads, unmapped offsets read zero
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            IRQ_ENABLE_LINK_ADDR: state_next.rdata = state_reg.irq_en;
            IRQ_STATUS_LINK_ADDR: state_next.rdata = state_reg.irq_st;
            SYSREF_EDGE_SKIP_COUNT_ADDR: state_next.rdata = state_reg.skip;
            SYSREF_JITTER_WINDOW_ADDR: state_next.rdata = state_reg.win;
            ONESHOT_SYNC_CONTROL_ADDR: begin
               state_next.rdata = REG_RESET;
               state_next.rdata[ONESHOT_REQ_BIT] = state_reg.req;
               state_next.rdata[ROTATION_DONE_BIT] = state_reg.done;
            end
            SYSREF_RECEIVER_CONFIG_ADDR: state_next.rdata = state_reg.sref_cfg;
            LINK_PAGE_SELECT_ADDR: state_next.rdata = state_reg.page;
            LANE_MAP_0_1_ADDR, LANE_MAP_2_3_ADDR,
            LANE_MAP_4_5_ADDR, LANE_MAP_6_7_ADDR: begin
               state_next.rdata = {2'h0,
                  state_reg.src[{reg_req_i.addr[1:0], 1'b1}],
                  state_reg.src[{reg_req_i.addr[1:0], 1'b0}]};
            end
            LANE_FIFO_STATUS_A_ADDR: state_next.rdata = fifo_full;
            LANE_FIFO_STATUS_B_ADDR: state_next.rdata = fifo_empty;
            LANE_POLARITY_INVERT_ADDR: state_next.rdata = state_reg.inv;
            DESCRAMBLER_CONFIG_ADDR: state_next.rdata = state_reg.scr_cfg[pg];
            LINK_SUBCLASS_CONFIG_ADDR: state_next.rdata = state_reg.sub_cfg[pg];
            default: state_next.rdata = REG_RESET;
         endcase
      end

      // interrupt output registered from the next gated status, so it changes in the same cycle as the status register
      state_next.irq = |(state_next.irq_st & state_next.irq_en);
   end

   // single state register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= reset_state();
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign reg_rdata_o = state_reg.rdata;
   assign frame_data_o = state_reg.fdata;
   assign frame_valid_o = state_reg.fvalid;
   assign link_sync_request_out_o = state_reg.sync_out;
   assign irq_o = state_reg.irq;
   assign sysref_coupling_select_o = state_reg.sref_cfg[COUPLING_BIT];

endmodule

// ==== rtl/lane_sync_pkg.sv ====
package lane_sync_pkg;
   // register offsets
   localparam logic [11:0] IRQ_ENABLE_LINK_ADDR = 12'h020;
   localparam logic [11:0] IRQ_STATUS_LINK_ADDR = 12'h024;
   localparam logic [11:0] SYSREF_EDGE_SKIP_COUNT_ADDR = 12'h036;
   localparam logic [11:0] SYSREF_JITTER_WINDOW_ADDR = 12'h039;
   localparam logic [11:0] ONESHOT_SYNC_CONTROL_ADDR = 12'h03A;
   localparam logic [11:0] SYSREF_RECEIVER_CONFIG_ADDR = 12'h084;
   localparam logic [11:0] LINK_PAGE_SELECT_ADDR = 12'h300;
   localparam logic [11:0] LANE_MAP_0_1_ADDR = 12'h308;
   localparam logic [11:0] LANE_MAP_2_3_ADDR = 12'h309;
   localparam logic [11:0] LANE_MAP_4_5_ADDR = 12'h30A;
   localparam logic [11:0] LANE_MAP_6_7_ADDR = 12'h30B;
   localparam logic [11:0] LANE_FIFO_STATUS_A_ADDR = 12'h30C;
   localparam logic [11:0] LANE_FIFO_STATUS_B_ADDR = 12'h30D;
   localparam logic [11:0] LANE_POLARITY_INVERT_ADDR = 12'h334;
   localparam logic [11:0] DESCRAMBLER_CONFIG_ADDR = 12'h453;
   localparam logic [11:0] LINK_SUBCLASS_CONFIG_ADDR = 12'h458;
   // field positions
   localparam int IRQ_JITTER_BIT = 0;
   localparam int IRQ_LANE_FIFO_BIT = 2;
   localparam int ONESHOT_REQ_BIT = 1;
   localparam int ROTATION_DONE_BIT = 4;
   localparam int PAGE_SEL_BIT = 2;
   localparam int COUPLING_BIT = 6;
   localparam int DESCRAMBLE_ENABLE_BIT = 7;
   localparam int SUBCLASS_LSB = 5;
   localparam int SRC_HI_LSB = 3;
   // reset values and the subclass one code
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] LANE_COUNT_RESET = 8'h03;
   localparam logic [2:0] SUBCLASS_ONE = 3'h1;
   // lane and fifo geometry
   localparam int NUM_LANES = 8;
   localparam int LANES_PER_LINK = 4;
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 4;
   localparam int PTR_W = 3;
   // timing: sysref sampled at dac clock divided by this
   localparam int SYSREF_SAMPLE_DIV = 4;
   localparam logic [1:0] SAMPLE_DIV_LAST = 2'(SYSREF_SAMPLE_DIV - 1);
   // local multiframe period in sysref sample ticks
   localparam int LMFC_TICKS = 16;
   localparam logic [3:0] LMFC_LAST = 4'(LMFC_TICKS - 1);
   localparam logic [3:0] LMFC_HALF = 4'(LMFC_TICKS / 2);

   typedef logic [NUM_LANES-1:0][WORD_W-1:0] lane_bus_t;

   typedef enum logic [1:0] {
      SYNC_IDLE,
      SYNC_ARMED,
      SYNC_MONITOR
   } sync_state_t;

   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;
endpackage

// ==== verification/lane_sync_rx_chk.sv ====
`timescale 1ns/1ns
module lane_sync_rx_chk
   import lane_sync_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   // lanes and sysref
   input wire logic [NUM_LANES-1:0] lane_valid_i,
   input wire logic sysref_i,
   // outputs watched
   input wire logic [NUM_LANES-1:0] frame_valid_o,
   input wire logic [1:0] link_sync_request_out_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic req_reg, page_reg, sc1_reg, skip0_reg, fresh;
   logic [7:0] en_reg;
   logic [3:0] quiet_reg;
   logic [15:0] wcnt_reg, pcnt_reg;
   logic [11:0] wa;
   // only a 0 to 1 change of the request bit starts a sync
   assign wa = reg_req_i.wr ? reg_req_i.addr : 12'hFFF;
   assign fresh = wa == ONESHOT_SYNC_CONTROL_ADDR
      && reg_req_i.wdata[ONESHOT_REQ_BIT] && !req_reg;
   // shadow of the control state the properties depend on
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_reg <= 1'b0;
         page_reg <= 1'b0;
         sc1_reg <= 1'b0;
         skip0_reg <= 1'b1;
         en_reg <= 8'h00;
         quiet_reg <= 4'h0;
         wcnt_reg <= 16'h0000;
         pcnt_reg <= 16'h0000;
      end else begin
         if (wa == ONESHOT_SYNC_CONTROL_ADDR)
            req_reg <= reg_req_i.wdata[ONESHOT_REQ_BIT];
         if (wa == LINK_PAGE_SELECT_ADDR)
            page_reg <= reg_req_i.wdata[PAGE_SEL_BIT];
         if (wa == LINK_SUBCLASS_CONFIG_ADDR && !page_reg)
            sc1_reg <= reg_req_i.wdata[7:5] == SUBCLASS_ONE;
         if (wa == SYSREF_EDGE_SKIP_COUNT_ADDR)
            skip0_reg <= reg_req_i.wdata == 8'h00;
         if (wa == IRQ_ENABLE_LINK_ADDR)
            en_reg <= reg_req_i.wdata;
         quiet_reg <= sysref_i ? 4'h0 : quiet_reg + 4'(quiet_reg != 4'hF);
         wcnt_reg <= wcnt_reg + 16'(lane_valid_i[0]);
         pcnt_reg <= pcnt_reg + 16'(frame_valid_o != 8'h00);
      end
   end
   a_unmapped_zero: assert property (
      reg_req_i.rd && reg_req_i.addr == 12'h0FF |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (
      !$past(reg_req_i.rd) && !reg_req_i.rd |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_irq_needs_enable: assert property (
      irq_o |-> (en_reg | $past(en_reg)) != 8'h00)
      else $error("interrupt raised with all sources masked");
   a_sync_drop: assert property (
      fresh |=> link_sync_request_out_o == 2'b00)
      else $error("sync request outputs not dropped");
   a_sc0_release: assert property (
      fresh && !sc1_reg && skip0_reg |-> ##2 link_sync_request_out_o == 2'b11)
      else $error("internal edge alignment late");
   a_sync_stays_up: assert property (
      link_sync_request_out_o == 2'b11 && !fresh && !$past(fresh)
      |=> link_sync_request_out_o == 2'b11)
      else $error("sync outputs fell without a request");
   a_sc1_waits_edge: assert property (
      link_sync_request_out_o == 2'b00 && sc1_reg && quiet_reg == 4'hF
      |=> link_sync_request_out_o == 2'b00)
      else $error("alignment without a sysref edge");
   a_pops_need_data: assert property (
      pcnt_reg <= wcnt_reg)
      else $error("more frames than words written");
   c_fresh: cover property (fresh);
   c_irq: cover property (irq_o);
   c_frames: cover property (frame_valid_o == 8'hFF);
endmodule

bind lane_sync_rx lane_sync_rx_chk chk_u (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o),
   .lane_valid_i(lane_valid_i),
   .sysref_i(sysref_i),
   .frame_valid_o(frame_valid_o),
   .link_sync_request_out_o(link_sync_request_out_o),
   .irq_o(irq_o)
);

// ==== verification/sysref_source.sv ====
`timescale 1ns/1ns
module sysref_source (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // waveform control
   input wire logic run_i,
   input wire logic [5:0] offset_i,
   // pulse and tally of rising edges sent
   output logic sysref_o,
   output logic [7:0] rises_o
);
   logic [5:0] cnt_reg;
   logic [5:0] phase;
   // period of 64 clocks is one multiframe; run_i low gaps the pulses
   assign phase = cnt_reg - offset_i;
   // high 8 clocks, twice the 4 dac periods between samples, so no sample misses it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 6'h00;
         sysref_o <= 1'b0;
         rises_o <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 6'h01;
         sysref_o <= run_i && phase < 6'h08;
         if (run_i && phase == 6'h00)
            rises_o <= rises_o + 8'h01;
      end
   end
endmodule

// ==== verification/jesd_rx_lane_map_and_sysref_sync_bench.sv ====
`timescale 1ns/1ns
module jesd_rx_lane_map_and_sysref_sync_bench;
   import lane_sync_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   reg_req_t reg_req_i = '0;
   lane_bus_t serial_lane_input_i = '0;
   lane_bus_t frame_data_o;
   logic [7:0] lane_valid_i = 8'h00;
   logic [7:0] frame_valid_o, reg_rdata_o, rises, rd_val, base;
   logic [7:0] inv = 8'h00;
   logic [7:0] dsc_en = 8'h00;
   logic [1:0] link_sync_request_out_o;
   logic irq_o, sysref_i, sysref_raw, coupling, run_reg = 1'b0;
   logic [5:0] offset_reg = 6'h00;
   logic [31:0] seed = 32'h00008B89;
   logic [2:0] map [8];
   logic [14:0] st [8];
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #5 clk_i = ~clk_i;
   // held low through reset so the pin is never unknown
   assign sysref_i = sysref_raw && resetn_i;
   lane_sync_rx dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
      .serial_lane_input_i(serial_lane_input_i),
      .lane_valid_i(lane_valid_i), .sysref_i(sysref_i),
      .frame_data_o(frame_data_o), .frame_valid_o(frame_valid_o),
      .link_sync_request_out_o(link_sync_request_out_o),
      .irq_o(irq_o), .sysref_coupling_select_o(coupling));
   sysref_source src_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .run_i(run_reg), .offset_i(offset_reg), .sysref_o(sysref_raw),
      .rises_o(rises));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // state shifts in every received bit, used or not
   function automatic logic [31:0] descr(inout logic [14:0] s,
         input logic [31:0] w, input logic en);
      logic [31:0] o;
      for (int i = 31; i >= 0; i--) begin
         o[i] = w[i] ^ s[13] ^ s[14];
         s = {s[13:0], w[i]};
      end
      return en ? o : w;
   endfunction
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // bus tasks start and end on a falling edge
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk_i);
      reg_req_i.wr <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rd(logic [11:0] a);
      reg_req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk_i);
      reg_req_i.rd <= 1'b0;
      @(negedge clk_i);
      rd_val = reg_rdata_o;
   endtask
   task automatic waitn(int n);
      repeat (n) @(negedge clk_i);
   endtask
   // upper lanes arrive two cycles late to exercise the fifo slack
   task automatic push();
      logic [31:0] w;
      lane_bus_t ex;
      for (int p = 0; p < 8; p++)
         serial_lane_input_i[p] = rnd();
      for (int l = 0; l < 8; l++) begin
         w = serial_lane_input_i[map[l]] ^ {32{inv[l]}};
         ex[l] = descr(st[l], w, dsc_en[l]);
      end
      lane_valid_i <= 8'h0F;
      waitn(1);
      lane_valid_i <= 8'h00;
      waitn(1);
      lane_valid_i <= 8'hF0;
      waitn(1);
      lane_valid_i <= 8'h00;
      for (int i = 0; i < 8 && frame_valid_o === 8'h00; i++)
         waitn(1);
      check("frame valid", frame_valid_o, 8'hFF);
      for (int l = 0; l < 8; l++)
         check("lane word", frame_data_o[l], ex[l]);
   endtask
   // a hung run counts as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      for (int l = 0; l < 8; l++) begin
         map[l] = 3'(l);
         st[l] = 15'h0000;
      end
      waitn(6);
      resetn_i = 1'b1;
      waitn(1);
      for (int k = 0; k < 4; k++) begin
         rd(LANE_MAP_0_1_ADDR + 12'(k));
         check("lane map", rd_val, {2'b00, 3'(2*k+1), 3'(2*k)});
      end
      rd(LANE_FIFO_STATUS_A_ADDR);
      check("fifo full", rd_val, 8'h00);
      rd(LANE_FIFO_STATUS_B_ADDR);
      check("fifo empty", rd_val, 8'hFF);
      rd(12'h0FF);
      check("unmapped", rd_val, 8'h00);
      // coupling select pin follows its config bit
      check("coupling", coupling, 1'b0);
      wr(SYSREF_RECEIVER_CONFIG_ADDR, 8'h40);
      check("coupling set", coupling, 1'b1);
      for (int n = 0; n < 6; n++) begin
         if (n == 2) begin
            inv = 8'(rnd());
            wr(LANE_POLARITY_INVERT_ADDR, inv);
            for (int k = 0; k < 4; k++) begin
               base = 8'(rnd());
               map[2*k] = base[2:0];
               map[2*k+1] = base[5:3];
               wr(LANE_MAP_0_1_ADDR + 12'(k), {2'b00, base[5:0]});
            end
         end
         if (n == 4) begin
            wr(DESCRAMBLER_CONFIG_ADDR, 8'h83);
            dsc_en = 8'h0F;
         end
         push();
      end
      wr(LINK_PAGE_SELECT_ADDR, 8'h04);
      rd(DESCRAMBLER_CONFIG_ADDR);
      check("page one", rd_val, 8'h03);
      wr(LINK_PAGE_SELECT_ADDR, 8'h00);
      rd(DESCRAMBLER_CONFIG_ADDR);
      check("page zero", rd_val, 8'h83);
      // internal alignment edge, each skipped edge costs a cycle; the
      // request is driven here so a one cycle drop is still seen
      for (int k = 0; k < 3; k++) begin
         wr(SYSREF_EDGE_SKIP_COUNT_ADDR, 8'(k));
         wr(ONESHOT_SYNC_CONTROL_ADDR, 8'h00);
         reg_req_i <= '{addr: ONESHOT_SYNC_CONTROL_ADDR, wr: 1'b1,
            rd: 1'b0, wdata: 8'h02};
         waitn(1);
         reg_req_i.wr <= 1'b0;
         for (int i = 0; i <= k; i++) begin
            check("sync dropped", link_sync_request_out_o, 2'b00);
            waitn(1);
         end
         check("sync back", link_sync_request_out_o, 2'b11);
         rd(ONESHOT_SYNC_CONTROL_ADDR);
         check("done", rd_val[ROTATION_DONE_BIT], 1'b1);
      end
      // sysref alignment; sync requested just after a pulse ends
      wr(LINK_SUBCLASS_CONFIG_ADDR, 8'h20);
      wr(SYSREF_EDGE_SKIP_COUNT_ADDR, 8'h01);
      wr(SYSREF_JITTER_WINDOW_ADDR, 8'h13);
      wr(ONESHOT_SYNC_CONTROL_ADDR, 8'h00);
      run_reg = 1'b1;
      @(negedge sysref_i);
      waitn(1);
      base = rises;
      wr(ONESHOT_SYNC_CONTROL_ADDR, 8'h02);
      rd(ONESHOT_SYNC_CONTROL_ADDR);
      check("done cleared", rd_val[ROTATION_DONE_BIT], 1'b0);
      for (int i = 0; i < 200 && link_sync_request_out_o !== 2'b11; i++)
         waitn(1);
      check("edges used", rises - base, 8'h02);
      // edges seen before this sync were judged against an older lmfc
      wr(IRQ_STATUS_LINK_ADDR, 8'h01);
      // lane traffic still flows once the rotation is done
      push();
      for (int j = 0; j < 3; j++) begin
         @(negedge sysref_i);
         waitn(20);
         offset_reg = (j == 2) ? 6'h00 : 6'h10;
         if (j == 1)
            wr(SYSREF_JITTER_WINDOW_ADDR, 8'h0C);
         repeat (2) @(posedge sysref_i);
         waitn(12);
         rd(IRQ_STATUS_LINK_ADDR);
         check("jitter", rd_val, {7'h00, j != 0});
      end
      check("masked irq", irq_o, 1'b0);
      wr(IRQ_ENABLE_LINK_ADDR, 8'h01);
      waitn(1);
      check("jitter irq", irq_o, 1'b1);
      wr(IRQ_STATUS_LINK_ADDR, 8'h01);
      waitn(1);
      check("jitter clear", irq_o, 1'b0);
      // lane 0 alone overflows its four deep fifo
      wr(IRQ_ENABLE_LINK_ADDR, 8'h04);
      lane_valid_i <= 8'h01;
      waitn(5);
      lane_valid_i <= 8'h00;
      waitn(2);
      check("fifo irq", irq_o, 1'b1);
      rd(LANE_FIFO_STATUS_A_ADDR);
      check("fifo full", rd_val, 8'h01);
      rd(LANE_FIFO_STATUS_B_ADDR);
      check("fifo empty", rd_val, 8'hFE);
      rd(IRQ_STATUS_LINK_ADDR);
      check("fifo status", rd_val, 8'h04);
      wr(IRQ_STATUS_LINK_ADDR, 8'h04);
      waitn(1);
      check("fifo clear", irq_o, 1'b0);
      close_out();
   end
endmodule
